// ---- inc/aer_defines.svh ----
// Purpose: constants of the analog module error reporting block
// Assumes: 10 MHz aclk, 32-bit AXI4-Lite register access
// Notes: offsets are byte addresses
`ifndef AER_DEFINES_SVH
`define AER_DEFINES_SVH
`define AER_ADDR_W 8
`define AER_OFF_ERR 8'h00
`define AER_OFF_CFG 8'h04
`define AER_OFF_ACT 8'h08
`define AER_OFF_OUT0 8'h0C
`define AER_OFF_OUT1 8'h10
`define AER_OFF_RANGE 8'h14
`define AER_OFF_ISTAT 8'h18
`define AER_OFF_IMASK 8'h1C
`define AER_RESP_OKAY 2'h0
`define AER_RESP_SLVERR 2'h2
`define AER_CLASS_LSB 9
`define AER_CLASS_NONE 3'h0
`define AER_CLASS_HW 3'h1
`define AER_CLASS_CFG 3'h2
`define AER_EXT_GENERAL 9'h000
`define AER_EXT_POWERUP 9'h001
`define AER_EXT_HW_SPECIFIC 9'h010
`define AER_CFG_FIELD_W 3
`define AER_CFG_FIELDS 4
`define AER_CFG_USED 12
`define AER_CFG_FMT_MAX 3'h4
`define AER_CFG_RESET 32'h0000_0000
`define AER_IRQ_HW 0
`define AER_IRQ_CFG 1
`define AER_IRQ_RANGE 2
`define AER_IRQ_DONE 3
`define AER_IRQ_W 4
`define AER_CLK_NS 100
`define AER_SELFTEST_NS 100000
`define AER_SELFTEST_CYC ((`AER_SELFTEST_NS + `AER_CLK_NS - 1) / `AER_CLK_NS)
`endif

// ---- inc/aer_pkg.sv ----
// Purpose: types of the analog module error reporting block
// Assumes: nothing beyond the defines header
// Notes: holds types only
package aer_pkg;
    typedef logic [15:0] aer_word_t;
    typedef enum logic [1:0] {AER_ST_POR, AER_ST_TEST, AER_ST_RUN, AER_ST_HALT} aer_state_t;
endpackage

// ---- verilog/aer_top.sv ----
// Purpose: power-up self test, error word, config check and output safing
// Assumes: fault and range pins are asynchronous and are synchronised here
// Notes: registers on AXI4-Lite; one write and one read at a time
`timescale 1ns/1ns
`include "aer_defines.svh"

// Operation
// - error word: bits 15-12 zero, 11-9 error class, 8-0 extended info.
// - class codes 000 none, 001 hardware, 010 configuration.
// - extended info is zero whenever the class says no error.
// - invalid configuration is discarded, flagged, previous setup kept; the code flags it in run state only.
// - config codes X400 general, X401-X402 input format, X403-X404 output format.
// - X200 general hardware, X201 power-up reset state, X210 hardware specific.
// - any fault forces all analog outputs to zero.
// - self test runs after every power-up.
// - status indicator lit in proper operation, dark on module fault.
// - over and under range flags go to input data, not error word.
// - hardware errors reported to controller, which records them.
// - non-critical errors recoverable; config errors shown by extended code.
module aer_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [`AER_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`AER_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic hw_fault_in,
    input wire logic hw_specific_in,
    input wire logic selftest_fail_in,
    input wire logic [1:0] range_over_in,
    input wire logic [1:0] range_under_in,
    output aer_pkg::aer_word_t err_word_out,
    output logic critical_err,
    output logic status_led,
    output logic [15:0] aout0,
    output logic [15:0] aout1,
    output logic irq
);
    import aer_pkg::*;

    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] TEST_LAST = CNT_W'(`AER_SELFTEST_CYC - 1);

    // pin synchronisers: stage one feeds stage two only
    logic [6:0] pin_s1_r;
    logic [6:0] pin_s2_r;
    logic hw_s;
    logic spec_s;
    logic stfail_s;
    logic [3:0] range_s;

    // bus and register group
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] cfg_act_r, cfg_act_nxt;
    logic [15:0] out0_r, out0_nxt;
    logic [15:0] out1_r, out1_nxt;
    logic [15:0] aout0_r, aout0_nxt;
    logic [15:0] aout1_r, aout1_nxt;
    logic [3:0] range_r, range_nxt;
    logic [`AER_IRQ_W-1:0] istat_r, istat_nxt;
    logic [`AER_IRQ_W-1:0] imask_r, imask_nxt;
    logic irq_r, irq_nxt;
    logic wr_go;
    logic cfg_good;
    logic cfg_bad;
    logic [8:0] cfg_code;
    logic [31:0] cfg_cand;
    logic [9:0] cfg_res;
    logic [31:0] out0_m;
    logic [31:0] out1_m;

    // error and self test group
    aer_state_t st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [15:0] word_r, word_nxt;
    logic ev_hw_r, ev_hw_nxt;
    logic ev_cfg_r, ev_cfg_nxt;
    logic ev_done_r, ev_done_nxt;
    logic led_r, led_nxt;
    logic fault;

    function automatic logic [31:0] byte_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // lowest failing field wins the extended code; stray upper bits give the general code
    function automatic logic [9:0] cfg_check(input logic [31:0] v);
        logic [9:0] res;
        res = 10'h000;
        if (|v[31:`AER_CFG_USED])
        begin
            res = {1'b1, `AER_EXT_GENERAL};
        end
        else
        begin
            for (int i = `AER_CFG_FIELDS - 1; i >= 0; i--)
            begin
                if (v[i*`AER_CFG_FIELD_W +: `AER_CFG_FIELD_W] > `AER_CFG_FMT_MAX)
                begin
                    res = {1'b1, 9'(i + 1)};
                end
            end
        end
        return res;
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1_r <= 7'h00;
            pin_s2_r <= 7'h00;
        end
        else if (ce)
        begin
            pin_s1_r <= {range_under_in, range_over_in, selftest_fail_in, hw_specific_in, hw_fault_in};
            pin_s2_r <= pin_s1_r;
        end
    end

    assign hw_s = pin_s2_r[0];
    assign spec_s = pin_s2_r[1];
    assign stfail_s = pin_s2_r[2];
    assign range_s = pin_s2_r[6:3];

    assign fault = (word_r[11:`AER_CLASS_LSB] != `AER_CLASS_NONE);

    assign wr_go = ce && awvalid && wvalid && !bvalid_r;
    assign awready = wr_go;
    assign wready = wr_go;
    assign arready = ce && arvalid && !rvalid_r;

    always_comb
    begin
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        cfg_act_nxt = cfg_act_r;
        out0_nxt = out0_r;
        out1_nxt = out1_r;
        imask_nxt = imask_r;
        cfg_good = 1'b0;
        cfg_bad = 1'b0;
        cfg_cand = byte_merge(cfg_act_r, wdata, wstrb);
        cfg_res = cfg_check(cfg_cand);
        cfg_code = cfg_res[8:0];
        out0_m = byte_merge({16'h0000, out0_r}, wdata, wstrb);
        out1_m = byte_merge({16'h0000, out1_r}, wdata, wstrb);
        istat_nxt = istat_r;
        if (bvalid_r && bready)
        begin
            bvalid_nxt = 1'b0;
        end
        if (rvalid_r && rready)
        begin
            rvalid_nxt = 1'b0;
        end
        if (wr_go)
        begin
            bvalid_nxt = 1'b1;
            bresp_nxt = `AER_RESP_OKAY;
            case (awaddr)
                `AER_OFF_CFG:
                begin
                    if (cfg_res[9])
                    begin
                        cfg_bad = 1'b1;
                    end
                    else
                    begin
                        cfg_good = 1'b1;
                        cfg_act_nxt = cfg_cand;
                    end
                end
                `AER_OFF_OUT0: out0_nxt = out0_m[15:0];
                `AER_OFF_OUT1: out1_nxt = out1_m[15:0];
                `AER_OFF_ISTAT: istat_nxt = istat_r & ~wdata[`AER_IRQ_W-1:0];
                `AER_OFF_IMASK: imask_nxt = wdata[`AER_IRQ_W-1:0];
                `AER_OFF_ERR, `AER_OFF_ACT, `AER_OFF_RANGE: bresp_nxt = `AER_RESP_OKAY;
                default: bresp_nxt = `AER_RESP_SLVERR;
            endcase
        end
        // a new event wins over a clear in the same cycle
        istat_nxt[`AER_IRQ_HW] = istat_nxt[`AER_IRQ_HW] | ev_hw_r;
        istat_nxt[`AER_IRQ_CFG] = istat_nxt[`AER_IRQ_CFG] | ev_cfg_r;
        istat_nxt[`AER_IRQ_RANGE] = istat_nxt[`AER_IRQ_RANGE] | (|(range_s & ~range_r));
        istat_nxt[`AER_IRQ_DONE] = istat_nxt[`AER_IRQ_DONE] | ev_done_r;
        range_nxt = range_s;
        irq_nxt = |(istat_nxt & imask_nxt);
        if (arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `AER_RESP_OKAY;
            case (araddr)
                `AER_OFF_ERR: rdata_nxt = {16'h0000, word_r};
                `AER_OFF_CFG, `AER_OFF_ACT: rdata_nxt = cfg_act_r;
                `AER_OFF_OUT0: rdata_nxt = {16'h0000, out0_r};
                `AER_OFF_OUT1: rdata_nxt = {16'h0000, out1_r};
                `AER_OFF_RANGE: rdata_nxt = {28'h0000000, range_r};
                `AER_OFF_ISTAT: rdata_nxt = {28'h0000000, istat_r};
                `AER_OFF_IMASK: rdata_nxt = {28'h0000000, imask_r};
                default:
                begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = `AER_RESP_SLVERR;
                end
            endcase
        end
        // outputs are zero from the cycle after any fault class is shown
        aout0_nxt = fault ? 16'h0000 : out0_r;
        aout1_nxt = fault ? 16'h0000 : out1_r;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= `AER_RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `AER_RESP_OKAY;
            cfg_act_r <= `AER_CFG_RESET;
            out0_r <= 16'h0000;
            out1_r <= 16'h0000;
            aout0_r <= 16'h0000;
            aout1_r <= 16'h0000;
            range_r <= 4'h0;
            istat_r <= 4'h0;
            imask_r <= 4'h0;
            irq_r <= 1'b0;
        end
        else if (ce)
        begin
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            cfg_act_r <= cfg_act_nxt;
            out0_r <= out0_nxt;
            out1_r <= out1_nxt;
            aout0_r <= aout0_nxt;
            aout1_r <= aout1_nxt;
            range_r <= range_nxt;
            istat_r <= istat_nxt;
            imask_r <= imask_nxt;
            irq_r <= irq_nxt;
        end
    end

    // error word: the upper nibble is never written, so it always reads zero
    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        word_nxt = word_r;
        ev_hw_nxt = 1'b0;
        ev_cfg_nxt = 1'b0;
        ev_done_nxt = 1'b0;
        unique case (st_r)
            AER_ST_POR:
            begin
                word_nxt = {4'h0, `AER_CLASS_HW, `AER_EXT_POWERUP};
                cnt_nxt = '0;
                st_nxt = AER_ST_TEST;
            end
            AER_ST_TEST:
            begin
                cnt_nxt = cnt_r + CNT_W'(1);
                if (stfail_s || hw_s)
                begin
                    word_nxt = {4'h0, `AER_CLASS_HW, `AER_EXT_GENERAL};
                    st_nxt = AER_ST_HALT;
                    ev_hw_nxt = 1'b1;
                    ev_done_nxt = 1'b1;
                end
                else if (cnt_r == TEST_LAST)
                begin
                    word_nxt = {4'h0, `AER_CLASS_NONE, 9'h000};
                    st_nxt = AER_ST_RUN;
                    ev_done_nxt = 1'b1;
                end
            end
            AER_ST_RUN:
            begin
                if (hw_s || spec_s)
                begin
                    // hardware faults are critical and stay until the next reset
                    word_nxt = {4'h0, `AER_CLASS_HW, hw_s ? `AER_EXT_GENERAL : `AER_EXT_HW_SPECIFIC};
                    st_nxt = AER_ST_HALT;
                    ev_hw_nxt = 1'b1;
                end
                else if (cfg_bad)
                begin
                    word_nxt = {4'h0, `AER_CLASS_CFG, cfg_code};
                    ev_cfg_nxt = 1'b1;
                end
                else if (cfg_good)
                begin
                    word_nxt = {4'h0, `AER_CLASS_NONE, 9'h000};
                end
            end
            AER_ST_HALT:
            begin
                st_nxt = AER_ST_HALT;
            end
        endcase
        led_nxt = (st_nxt == AER_ST_RUN);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= AER_ST_POR;
            cnt_r <= '0;
            word_r <= {4'h0, `AER_CLASS_HW, `AER_EXT_POWERUP};
            ev_hw_r <= 1'b0;
            ev_cfg_r <= 1'b0;
            ev_done_r <= 1'b0;
            led_r <= 1'b0;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            word_r <= word_nxt;
            ev_hw_r <= ev_hw_nxt;
            ev_cfg_r <= ev_cfg_nxt;
            ev_done_r <= ev_done_nxt;
            led_r <= led_nxt;
        end
    end

    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign err_word_out = word_r;
    assign critical_err = (st_r == AER_ST_HALT);
    assign status_led = led_r;
    assign aout0 = aout0_r;
    assign aout1 = aout1_r;
    assign irq = irq_r;
endmodule

// ---- verification/aer_ctrl_model.sv ----
// Purpose: controller side that watches the module error word
// Assumes: samples on aclk, reset with aresetn
// Notes: keeps only what the tests look at
`timescale 1ns/1ns
`include "aer_defines.svh"
module aer_ctrl_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire aer_pkg::aer_word_t err_word,
    input wire logic critical_err,
    output logic run_mode,
    output aer_pkg::aer_word_t io_status
);
    import aer_pkg::*;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_mode <= 1'b1;
            io_status <= '0;
        end
        else
        begin
            // last hardware class word is kept as the status record
            if (err_word[11:9] == `AER_CLASS_HW)
                io_status <= err_word;
            if (critical_err)
                run_mode <= 1'b0;
        end
    end
endmodule

// ---- verification/aer_top_assertions.sv ----
// Purpose: port checks of aer_top
// Assumes: one clock, aresetn synchronous active low
// Notes: bound into aer_top
`timescale 1ns/1ns
`include "aer_defines.svh"
module aer_top_assertions
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic wvalid,
    input wire logic awready,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire aer_pkg::aer_word_t err_word_out,
    input wire logic critical_err,
    input wire logic status_led,
    input wire logic [15:0] aout0,
    input wire logic [15:0] aout1
);
    import aer_pkg::*;
    logic [2:0] cls;
    assign cls = err_word_out[11:9];
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_top_zero; err_word_out[15:12] == 4'h0; endproperty
    a_top_zero: assert property (p_top_zero) else $error("error word top bits set");
    property p_class; cls inside {`AER_CLASS_NONE, `AER_CLASS_HW, `AER_CLASS_CFG}; endproperty
    a_class: assert property (p_class) else $error("bad error class");
    property p_ext_zero; cls == `AER_CLASS_NONE |-> err_word_out[8:0] == 9'h000; endproperty
    a_ext_zero: assert property (p_ext_zero) else $error("extended info without class");
    property p_cfg_code; cls == `AER_CLASS_CFG |-> err_word_out[8:0] <= 9'h004; endproperty
    a_cfg_code: assert property (p_cfg_code) else $error("bad config code");
    // one cycle of grace, outputs are registered from the already registered word
    property p_safe_out; cls != 3'h0 && $past(cls) != 3'h0 |-> aout0 == 16'h0 && aout1 == 16'h0; endproperty
    a_safe_out: assert property (p_safe_out) else $error("outputs live under fault");
    property p_led_dark; critical_err |-> !status_led && cls == `AER_CLASS_HW; endproperty
    a_led_dark: assert property (p_led_dark) else $error("led lit on fault");
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_w_ans; awvalid && wvalid && awready && wready |=> bvalid; endproperty
    a_w_ans: assert property (p_w_ans) else $error("write not answered");
endmodule
bind aer_top aer_top_assertions u_aer_top_assertions (.aclk, .aresetn, .awvalid, .wvalid, .awready,
    .wready, .bresp, .bvalid, .bready, .rdata, .rvalid, .rready, .err_word_out, .critical_err,
    .status_led, .aout0, .aout1);

// ---- verification/aer_top_tb_top.sv ----
// Purpose: register level test of aer_top
// Assumes: 100 ns clock, ce held high
// Notes: AXI4-Lite tasks, bounded waits
`timescale 1ns/1ns
`include "aer_defines.svh"
module aer_top_tb_top;
    logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic hw_fault_in = 0, hw_specific_in = 0, selftest_fail_in = 0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 0;
    logic [1:0] range_over_in = 0, range_under_in = 0, bresp, rresp, r;
    logic critical_err, status_led, irq, run_mode;
    logic [15:0] err_word_out, aout0, aout1, io_status;
    int miscompares = 0, n_tests = 0, i, k;
    always #50 aclk = ~aclk;
    aer_top u_aer_top (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .hw_fault_in,
        .hw_specific_in, .selftest_fail_in, .range_over_in, .range_under_in, .err_word_out, .critical_err,
        .status_led, .aout0, .aout1, .irq);
    aer_ctrl_model u_aer_ctrl_model (.aclk, .aresetn, .err_word(err_word_out), .critical_err, .run_mode,
        .io_status);
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 20)
        begin
            miscompares++;
            report_and_stop();
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // each channel is released at the edge that takes it; ready is only read at an edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 20 && !(awready === 1'b1 && wready === 1'b1); i++)
            @(posedge aclk);
        hang(i);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 20 && bvalid !== 1'b1; i++)
            @(posedge aclk);
        hang(i);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 20 && arready !== 1'b1; i++)
            @(posedge aclk);
        hang(i);
        arvalid <= 1'b0;
        rready <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 20 && rvalid !== 1'b1; i++)
            @(posedge aclk);
        hang(i);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    initial
    begin
        tick(10);
        aresetn <= 1'b1;
        tick(4);
        chk(32'(err_word_out), 32'h0201);
        chk(32'(status_led), 32'h0);
        chk({aout0, aout1}, 32'h0);
        for (k = 0; k < 1100 && status_led !== 1'b1; k++)
            @(posedge aclk);
        chk(32'(k > 900 && k < 1100), 32'h1);
        rd(`AER_OFF_ERR);
        chk(d, 32'h0);
        wr(`AER_OFF_IMASK, 32'h8);
        tick(2);
        chk(32'(irq), 32'h1);
        wr(`AER_OFF_ISTAT, 32'h8);
        tick(2);
        chk(32'(irq), 32'h0);
        wr(`AER_OFF_CFG, 32'h29C);
        wr(`AER_OFF_OUT0, 32'h1234);
        wr(`AER_OFF_OUT1, 32'hABCD);
        tick(2);
        chk({aout0, aout1}, 32'h1234ABCD);
        for (k = 0; k < 5; k++)
        begin
            // last pass sets a reserved bit instead of a bad field
            wr(`AER_OFF_CFG, k < 4 ? 32'h5 << (3 * k) : 32'h1000);
            rd(`AER_OFF_ERR);
            chk(d, k < 4 ? 32'h401 + k : 32'h400);
            rd(`AER_OFF_ACT);
            chk(d, 32'h29C);
            chk({aout0, aout1}, 32'h0);
            chk(32'(status_led), 32'h1);
        end
        chk(32'(irq), 32'h0);
        rd(`AER_OFF_ISTAT);
        chk(d, 32'h2);
        wr(`AER_OFF_IMASK, 32'h2);
        tick(2);
        chk(32'(irq), 32'h1);
        wr(`AER_OFF_ISTAT, 32'h2);
        wr(`AER_OFF_CFG, 32'h29C);
        tick(2);
        chk(32'({irq, err_word_out}), 32'h0);
        chk(32'(aout0), 32'h1234);
        range_over_in <= 2'b10;
        range_under_in <= 2'b01;
        tick(6);
        rd(`AER_OFF_RANGE);
        chk(d, 32'h6);
        chk(32'(err_word_out), 32'h0);
        rd(8'h40);
        chk(d, 32'h0);
        chk(32'(r), 32'(`AER_RESP_SLVERR));
        wr(8'h40, 32'h1);
        chk(32'(r), 32'(`AER_RESP_SLVERR));
        wr(`AER_OFF_ERR, 32'hFFFF);
        chk(32'({r, err_word_out}), 32'h0);
        hw_specific_in <= 1'b1;
        tick(5);
        chk(32'(err_word_out), 32'h0210);
        chk(32'({critical_err, status_led}), 32'h2);
        chk({aout0, aout1}, 32'h0);
        chk(32'({run_mode, io_status}), 32'h0210);
        aresetn <= 1'b0;
        hw_specific_in <= 1'b0;
        selftest_fail_in <= 1'b1;
        tick(3);
        aresetn <= 1'b1;
        tick(10);
        chk(32'({critical_err, err_word_out}), 32'h10200);
        // third start: test passes, then a general fault outranks a specific one
        aresetn <= 1'b0;
        selftest_fail_in <= 1'b0;
        tick(3);
        aresetn <= 1'b1;
        for (k = 0; k < 1100 && status_led !== 1'b1; k++)
            @(posedge aclk);
        chk(32'(status_led), 32'h1);
        hw_fault_in <= 1'b1;
        hw_specific_in <= 1'b1;
        tick(5);
        chk(32'(err_word_out), 32'h0200);
        rd(`AER_OFF_ISTAT);
        chk(d, 32'hD);
        report_and_stop();
    end
endmodule
